// *** hw/edge_qualifier.sv ***
`timescale 1ns/1ps
`default_nettype none
module edge_qualifier #(
  parameter int W = 16
) (
  input  wire logic         sys_clk,    // System clock
  input  wire logic         reset_n,    // Synchronous reset, active low
  input  wire logic [W-1:0] status,     // Live status bits
  input  wire logic [W-1:0] any_edge,   // 1: both edges count, 0: rising only
  input  wire logic [W-1:0] direct_evt, // Event pulses that bypass edge logic
  flag_bank_if.source       evt         // Set pulses toward the flag bank
);
  logic [W-1:0] prev_q;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      prev_q <= '0;
    end else begin
      prev_q <= status;
    end
  end

  // Falling edges only count where the select bit asks for them
  assign evt.set_p = direct_evt | (status & ~prev_q) | (any_edge & prev_q & ~status);
endmodule
`default_nettype wire

// *** hw/flag_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
module flag_bank #(
  parameter int W = 16
) (
  input  wire logic sys_clk, // System clock
  input  wire logic reset_n, // Synchronous reset, active low
  flag_bank_if.bank bnk      // Set, clear and flag vectors
);
  logic [W-1:0] flags_q;
  logic [W-1:0] held_q;
  logic [W-1:0] set_q;

  // Set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~bnk.clr) | bnk.set_p;
    end
  end

  assign bnk.flags = flags_q;

  always_ff @(posedge sys_clk) begin
    held_q <= flags_q & ~bnk.clr;
    set_q  <= bnk.set_p;
  end

  property p_flag_holds;
    @(posedge sys_clk) disable iff (!reset_n)
    $rose(reset_n) or ((flags_q & held_q) == held_q);
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("flag lost without clear");

  property p_set_lands;
    @(posedge sys_clk) disable iff (!reset_n)
    (bnk.set_p != '0) |=> ((flags_q & set_q) == set_q);
  endproperty
  a_set_lands: assert property (p_set_lands) else $error("set pulse missed its flag");
endmodule
`default_nettype wire

// *** hw/flag_bank_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface flag_bank_if #(
  parameter int W = 16
);
  logic [W-1:0] set_p;
  logic [W-1:0] clr;
  logic [W-1:0] flags;
  modport source (output set_p);
  modport bank   (input set_p, input clr, output flags);
endinterface
`default_nettype wire

// *** hw/liu_channel_interrupt_edge_mask.sv ***
//Contract
// - AIS edge bit 0 flags rising line/system AIS; 1 flags either edge.
// - Pattern-sync edge bit picks rising-only or any change for its flag.
// - Overcurrent edge bit picks rising-only or any change for its flag.
// - Transmit-clock-loss edge bit picks rising-only or any change.
// - Transmit signal-loss edge bit picks rising-only or any change.
// - One signal-loss edge bit governs line and system loss flags.
// - One in-band edge bit governs activate and deactivate code flags.
// - Edge select register resets to zero: rising edges only.
// - Each channel has its own register copy at a fixed address stride.
// - Mask bit 0 lets its source interrupt, 1 blocks it.
// - First mask register resets to all ones.
// - Mask bit 7 gates transmit amplitude overflow.
// - Mask bit 6 gates transmit jitter FIFO over- and underflow together.
// - Mask bit 5 gates receive jitter FIFO over- and underflow together.
// - Mask bit 4 gates line driver overcurrent.
// - Mask bit 3 gates transmit clock missing.
// - Mask bits 2,1,0 gate transmit, system and line signal loss.
`timescale 1ns/1ps
`default_nettype none
module liu_channel_interrupt_edge_mask #(
  parameter int NUM_CH = 16
) (
  input  wire logic              sys_clk,                        // 20 MHz clock
  input  wire logic              reset_n,                        // Sync reset, low
  input  wire logic [10:0]       reg_addr,                       // Byte address
  input  wire logic [7:0]        reg_wr_data,                    // Write data
  input  wire logic              reg_wr_stb,                     // Write strobe
  input  wire logic              reg_rd_stb,                     // Read strobe
  output logic      [7:0]        reg_rd_data,                    // Read data, next cycle
  input  wire logic [NUM_CH-1:0] line_signal_loss_status,        // Per channel
  input  wire logic [NUM_CH-1:0] system_signal_loss_status,      // Per channel
  input  wire logic [NUM_CH-1:0] tx_signal_loss_status,          // Per channel
  input  wire logic [NUM_CH-1:0] tx_clock_missing_status,        // Per channel
  input  wire logic [NUM_CH-1:0] overcurrent_status,             // Per channel
  input  wire logic [NUM_CH-1:0] deactivate_code_status,         // Per channel
  input  wire logic [NUM_CH-1:0] activate_code_status,           // Per channel
  input  wire logic [NUM_CH-1:0] pattern_sync_status,            // Per channel
  input  wire logic [NUM_CH-1:0] line_alarm_indication_status,   // Per channel
  input  wire logic [NUM_CH-1:0] system_alarm_indication_status, // Per channel
  input  wire logic [NUM_CH-1:0] rx_jitter_fifo_evt,             // Pulse per channel
  input  wire logic [NUM_CH-1:0] tx_jitter_fifo_evt,             // Pulse per channel
  input  wire logic [NUM_CH-1:0] amplitude_overflow_evt,         // Pulse per channel
  output logic                   irq                             // Level, high active
);
  localparam int FW = liu_irq_pkg::FLAG_W;

  if (NUM_CH < 1 || NUM_CH > liu_irq_pkg::MAX_CH) begin : g_bad_ch
    $error("NUM_CH must lie between 1 and 16");
  end

  logic [7:0]    edge_sel_q [NUM_CH];
  logic [7:0]    mask_a_q   [NUM_CH];
  logic [7:0]    mask_b_q   [NUM_CH];
  logic [FW-1:0] flags_w    [NUM_CH];
  logic [FW-1:0] status_w   [NUM_CH];
  logic [NUM_CH-1:0] pend_w;
  logic [7:0]    rd_data_q;
  logic          irq_q;

  // Address split: bit 10 must be clear, 9:6 picks the channel window
  wire [3:0] acc_ch   = reg_addr[liu_irq_pkg::CH_LSB +: 4];
  wire [5:0] acc_off  = reg_addr[liu_irq_pkg::OFF_W-1:0];
  wire       in_range = (reg_addr[10] == 1'b0) && ({28'h0, acc_ch} < NUM_CH);
  wire       wr_hit   = reg_wr_stb && in_range;

  wire hit_es = (acc_off == liu_irq_pkg::OFF_EDGE_SEL);
  wire hit_ma = (acc_off == liu_irq_pkg::OFF_MASK_A);
  wire hit_mb = (acc_off == liu_irq_pkg::OFF_MASK_B);
  wire hit_sa = (acc_off == liu_irq_pkg::OFF_STATUS_A);
  wire hit_sb = (acc_off == liu_irq_pkg::OFF_STATUS_B);
  wire hit_fa = (acc_off == liu_irq_pkg::OFF_FLAGS_A);
  wire hit_fb = (acc_off == liu_irq_pkg::OFF_FLAGS_B);

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    flag_bank_if #(.W(FW)) fbi ();
    logic [FW-1:0] any_edge;
    logic [FW-1:0] direct_evt;
    logic [7:0]    es;
    logic [7:0]    ma;
    wire           wr_ch = wr_hit && (acc_ch == 4'(g));

    assign es = edge_sel_q[g];
    assign ma = mask_a_q[g];

    assign status_w[g] = {system_alarm_indication_status[g], line_alarm_indication_status[g],
                          pattern_sync_status[g], 3'h0,
                          activate_code_status[g], deactivate_code_status[g],
                          3'h0, overcurrent_status[g], tx_clock_missing_status[g],
                          tx_signal_loss_status[g], system_signal_loss_status[g],
                          line_signal_loss_status[g]};

    // Shared select bits fan out to both flags they govern
    assign any_edge = {es[liu_irq_pkg::ES_AIS], es[liu_irq_pkg::ES_AIS],
                       es[liu_irq_pkg::ES_PA], 3'h0,
                       es[liu_irq_pkg::ES_IB], es[liu_irq_pkg::ES_IB],
                       3'h0, es[liu_irq_pkg::ES_TOC],
                       es[liu_irq_pkg::ES_TCKLOS],
                       es[liu_irq_pkg::ES_TLOS],
                       es[liu_irq_pkg::ES_LOS], es[liu_irq_pkg::ES_LOS]};

    // Jitter FIFO detectors already merge over- and underflow into one pulse
    assign direct_evt = {8'h00, amplitude_overflow_evt[g], tx_jitter_fifo_evt[g],
                         rx_jitter_fifo_evt[g], 5'h00};

    assign fbi.clr = (wr_ch && hit_fa) ? {8'h00, reg_wr_data} :
                     (wr_ch && hit_fb) ? {reg_wr_data & liu_irq_pkg::GRP_B_USE, 8'h00} :
                     '0;
    assign flags_w[g] = fbi.flags;

    edge_qualifier #(.W(FW)) u_qual (
      .sys_clk    (sys_clk),
      .reset_n    (reset_n),
      .status     (status_w[g]),
      .any_edge   (any_edge),
      .direct_evt (direct_evt),
      .evt        (fbi.source)
    );

    flag_bank #(.W(FW)) u_bank (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .bnk     (fbi.bank)
    );

    always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
        edge_sel_q[g] <= liu_irq_pkg::EDGE_SEL_RST;
        mask_a_q[g]   <= liu_irq_pkg::MASK_A_RST;
        mask_b_q[g]   <= liu_irq_pkg::MASK_B_RST;
      end else if (wr_ch) begin
        if (hit_es) edge_sel_q[g] <= reg_wr_data & liu_irq_pkg::EDGE_SEL_USE;
        if (hit_ma) mask_a_q[g] <= reg_wr_data;
        if (hit_mb) mask_b_q[g] <= reg_wr_data & liu_irq_pkg::GRP_B_USE;
      end
    end

    // Mask bit 0 enables; each bit lines up with its flag position
    assign pend_w[g] = |((flags_w[g][7:0] & ~mask_a_q[g]) |
                         (flags_w[g][15:8] & ~mask_b_q[g]));

    property p_ais_rise;
      @(posedge sys_clk) disable iff (!reset_n)
      (!es[liu_irq_pkg::ES_AIS] && $rose(line_alarm_indication_status[g]))
        |=> flags_w[g][liu_irq_pkg::FL_LAIS];
    endproperty
    a_ais_rise: assert property (p_ais_rise) else $error("line AIS rise not flagged");

    property p_ais_fall;
      @(posedge sys_clk) disable iff (!reset_n)
      (es[liu_irq_pkg::ES_AIS] && $fell(system_alarm_indication_status[g]))
        |=> flags_w[g][liu_irq_pkg::FL_SAIS];
    endproperty
    a_ais_fall: assert property (p_ais_fall) else $error("system AIS fall not flagged");

    property p_pa_fall;
      @(posedge sys_clk) disable iff (!reset_n)
      (es[liu_irq_pkg::ES_PA] && $fell(pattern_sync_status[g]))
        |=> flags_w[g][liu_irq_pkg::FL_PA];
    endproperty
    a_pa_fall: assert property (p_pa_fall) else $error("pattern sync fall not flagged");

    property p_toc_quiet;
      @(posedge sys_clk) disable iff (!reset_n)
      (!es[liu_irq_pkg::ES_TOC] && $fell(overcurrent_status[g])
        && !flags_w[g][liu_irq_pkg::FL_TOC]) |=> !flags_w[g][liu_irq_pkg::FL_TOC];
    endproperty
    a_toc_quiet: assert property (p_toc_quiet)
      else $error("overcurrent fall flagged in rise mode");

    property p_tck_fall;
      @(posedge sys_clk) disable iff (!reset_n)
      (es[liu_irq_pkg::ES_TCKLOS] && $fell(tx_clock_missing_status[g]))
        |=> flags_w[g][liu_irq_pkg::FL_TCKLOS];
    endproperty
    a_tck_fall: assert property (p_tck_fall) else $error("clock missing fall not flagged");

    property p_tlos_rise;
      @(posedge sys_clk) disable iff (!reset_n)
      $rose(tx_signal_loss_status[g]) |=> flags_w[g][liu_irq_pkg::FL_TLOS];
    endproperty
    a_tlos_rise: assert property (p_tlos_rise)
      else $error("tx signal loss rise not flagged");

    property p_los_shared;
      @(posedge sys_clk) disable iff (!reset_n)
      (es[liu_irq_pkg::ES_LOS] && $fell(system_signal_loss_status[g])
        && $fell(line_signal_loss_status[g]))
        |=> (flags_w[g][liu_irq_pkg::FL_SLOS] && flags_w[g][liu_irq_pkg::FL_LLOS]);
    endproperty
    a_los_shared: assert property (p_los_shared)
      else $error("shared loss select not honoured");

    property p_ib_fall;
      @(posedge sys_clk) disable iff (!reset_n)
      (es[liu_irq_pkg::ES_IB] && $fell(activate_code_status[g]))
        |=> flags_w[g][liu_irq_pkg::FL_IBA];
    endproperty
    a_ib_fall: assert property (p_ib_fall) else $error("activate code fall not flagged");

    property p_reset_vals;
      @(posedge sys_clk) disable iff (!reset_n)
      $rose(reset_n) |-> (es == liu_irq_pkg::EDGE_SEL_RST && ma == liu_irq_pkg::MASK_A_RST);
    endproperty
    a_reset_vals: assert property (p_reset_vals)
      else $error("wrong register reset value");

    property p_tja_irq;
      @(posedge sys_clk) disable iff (!reset_n)
      (tx_jitter_fifo_evt[g] && !ma[liu_irq_pkg::FL_TJA]
        && !(wr_ch && (hit_ma || hit_fa))) |-> ##2 irq;
    endproperty
    a_tja_irq: assert property (p_tja_irq) else $error("unmasked jitter FIFO event lost");

    property p_dac_masked;
      @(posedge sys_clk) disable iff (!reset_n)
      (ma == 8'hFF && mask_b_q[g] == liu_irq_pkg::GRP_B_USE) |-> !pend_w[g];
    endproperty
    a_dac_masked: assert property (p_dac_masked)
      else $error("masked source still pending");

    // Rise-only mode must ignore a fall; checked only while the flag is still clear
    property p_sais_quiet;
      @(posedge sys_clk) disable iff (!reset_n)
      (!es[liu_irq_pkg::ES_AIS] && $fell(system_alarm_indication_status[g])
        && !flags_w[g][liu_irq_pkg::FL_SAIS]) |=> !flags_w[g][liu_irq_pkg::FL_SAIS];
    endproperty
    a_sais_quiet: assert property (p_sais_quiet)
      else $error("system AIS fall flagged in rise mode");

    property p_pa_rise;
      @(posedge sys_clk) disable iff (!reset_n)
      (!es[liu_irq_pkg::ES_PA] && $rose(pattern_sync_status[g]))
        |=> flags_w[g][liu_irq_pkg::FL_PA];
    endproperty
    a_pa_rise: assert property (p_pa_rise)
      else $error("pattern sync rise not flagged");

    property p_toc_fall;
      @(posedge sys_clk) disable iff (!reset_n)
      (es[liu_irq_pkg::ES_TOC] && $fell(overcurrent_status[g]))
        |=> flags_w[g][liu_irq_pkg::FL_TOC];
    endproperty
    a_toc_fall: assert property (p_toc_fall)
      else $error("overcurrent fall not flagged");

    property p_tck_rise;
      @(posedge sys_clk) disable iff (!reset_n)
      $rose(tx_clock_missing_status[g]) |=> flags_w[g][liu_irq_pkg::FL_TCKLOS];
    endproperty
    a_tck_rise: assert property (p_tck_rise)
      else $error("clock missing rise not flagged");

    property p_tlos_fall;
      @(posedge sys_clk) disable iff (!reset_n)
      (es[liu_irq_pkg::ES_TLOS] && $fell(tx_signal_loss_status[g]))
        |=> flags_w[g][liu_irq_pkg::FL_TLOS];
    endproperty
    a_tlos_fall: assert property (p_tlos_fall)
      else $error("tx signal loss fall not flagged");

    property p_llos_quiet;
      @(posedge sys_clk) disable iff (!reset_n)
      (!es[liu_irq_pkg::ES_LOS] && $fell(line_signal_loss_status[g])
        && !flags_w[g][liu_irq_pkg::FL_LLOS]) |=> !flags_w[g][liu_irq_pkg::FL_LLOS];
    endproperty
    a_llos_quiet: assert property (p_llos_quiet)
      else $error("line loss fall flagged in rise mode");

    property p_ibd_fall;
      @(posedge sys_clk) disable iff (!reset_n)
      (es[liu_irq_pkg::ES_IB] && $fell(deactivate_code_status[g]))
        |=> flags_w[g][liu_irq_pkg::FL_IBD];
    endproperty
    a_ibd_fall: assert property (p_ibd_fall)
      else $error("deactivate code fall not flagged");

    // Event pulses bypass the edge logic, so one pulse must always land
    property p_rja_lands;
      @(posedge sys_clk) disable iff (!reset_n)
      rx_jitter_fifo_evt[g] |=> flags_w[g][liu_irq_pkg::FL_RJA];
    endproperty
    a_rja_lands: assert property (p_rja_lands)
      else $error("rx jitter FIFO event not flagged");

    property p_dac_lands;
      @(posedge sys_clk) disable iff (!reset_n)
      amplitude_overflow_evt[g] |=> flags_w[g][liu_irq_pkg::FL_DAC];
    endproperty
    a_dac_lands: assert property (p_dac_lands)
      else $error("amplitude overflow event not flagged");
  end

  wire [7:0] fa_sel = flags_w[acc_ch][7:0];
  wire [7:0] fb_sel = flags_w[acc_ch][15:8];
  wire [7:0] rd_word =
    !in_range ? 8'h00 :
    hit_es    ? edge_sel_q[acc_ch] :
    hit_ma    ? mask_a_q[acc_ch] :
    hit_mb    ? mask_b_q[acc_ch] :
    hit_sa    ? status_w[acc_ch][7:0] :
    hit_sb    ? status_w[acc_ch][15:8] :
    hit_fa    ? fa_sel :
    hit_fb    ? fb_sel :
    8'h00;

  // Read data lives for one cycle only, zero otherwise
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= reg_rd_stb ? rd_word : 8'h00;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |pend_w;
    end
  end

  assign reg_rd_data = rd_data_q;
  assign irq         = irq_q;

  property p_irq_follows;
    @(posedge sys_clk) disable iff (!reset_n)
    (|pend_w) |=> irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("pending source without irq");

  property p_irq_drops;
    @(posedge sys_clk) disable iff (!reset_n)
    !(|pend_w) |=> !irq;
  endproperty
  a_irq_drops: assert property (p_irq_drops) else $error("irq without pending source");

  property p_rd_one_cycle;
    @(posedge sys_clk) disable iff (!reset_n)
    !reg_rd_stb |=> (reg_rd_data == 8'h00);
  endproperty
  a_rd_one_cycle: assert property (p_rd_one_cycle)
    else $error("read data outside its cycle");
endmodule
`default_nettype wire

// *** hw/liu_irq_pkg.sv ***
package liu_irq_pkg;
  localparam int          ADDR_W       = 11;
  localparam int          DATA_W       = 8;
  localparam int          CH_LSB       = 6;
  localparam int          OFF_W        = 6;
  localparam int          MAX_CH       = 16;
  localparam int          FLAG_W       = 16;
  // Offsets inside one channel window of 64 bytes
  localparam logic [5:0]  OFF_EDGE_SEL = 6'h1A;
  localparam logic [5:0]  OFF_MASK_A   = 6'h1B;
  localparam logic [5:0]  OFF_MASK_B   = 6'h1C;
  localparam logic [5:0]  OFF_STATUS_A = 6'h1E;
  localparam logic [5:0]  OFF_STATUS_B = 6'h1F;
  localparam logic [5:0]  OFF_FLAGS_A  = 6'h20;
  localparam logic [5:0]  OFF_FLAGS_B  = 6'h21;
  localparam logic [7:0]  EDGE_SEL_RST = 8'h00;
  localparam logic [7:0]  MASK_A_RST   = 8'hFF;
  localparam logic [7:0]  MASK_B_RST   = 8'hE3;
  localparam logic [7:0]  EDGE_SEL_USE = 8'h7F;
  localparam logic [7:0]  GRP_B_USE    = 8'hE3;
  // Edge select fields
  localparam int          ES_IB        = 0;
  localparam int          ES_LOS       = 1;
  localparam int          ES_TLOS      = 2;
  localparam int          ES_TCKLOS    = 3;
  localparam int          ES_TOC       = 4;
  localparam int          ES_PA        = 5;
  localparam int          ES_AIS       = 6;
  // Flag positions, group a in 7:0, group b in 15:8
  localparam int          FL_LLOS      = 0;
  localparam int          FL_SLOS      = 1;
  localparam int          FL_TLOS      = 2;
  localparam int          FL_TCKLOS    = 3;
  localparam int          FL_TOC       = 4;
  localparam int          FL_RJA       = 5;
  localparam int          FL_TJA       = 6;
  localparam int          FL_DAC       = 7;
  localparam int          FL_IBD       = 8;
  localparam int          FL_IBA       = 9;
  localparam int          FL_PA        = 13;
  localparam int          FL_LAIS      = 14;
  localparam int          FL_SAIS      = 15;
endpackage

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int NCH     = 16;
  // Status sources 0..9 follow the ten status ports, 10..12 the three event pulses
  localparam int FLP[13] = '{liu_irq_pkg::FL_LLOS, liu_irq_pkg::FL_SLOS, liu_irq_pkg::FL_TLOS,
                             liu_irq_pkg::FL_TCKLOS, liu_irq_pkg::FL_TOC, liu_irq_pkg::FL_IBD,
                             liu_irq_pkg::FL_IBA, liu_irq_pkg::FL_PA, liu_irq_pkg::FL_LAIS,
                             liu_irq_pkg::FL_SAIS, liu_irq_pkg::FL_RJA, liu_irq_pkg::FL_TJA,
                             liu_irq_pkg::FL_DAC};
  localparam int ESB[10] = '{1, 1, 2, 3, 4, 0, 0, 5, 6, 6};

  logic           sys_clk;
  logic           reset_n;
  logic [10:0]    reg_addr;
  logic [7:0]     reg_wr_data;
  logic           reg_wr_stb;
  logic           reg_rd_stb;
  logic [7:0]     reg_rd_data;
  logic           irq;
  logic [NCH-1:0] st [10];
  logic [NCH-1:0] ev [3];
  logic           rd_seen;
  logic [7:0]     exp_q [$];
  logic [7:0]     es_v [NCH];
  logic [7:0]     ma_v [NCH];
  logic [31:0]    rs;
  int             n_errors;
  int             num_checks;

  liu_channel_interrupt_edge_mask #(.NUM_CH(NCH)) u_dut (
    .sys_clk                        (sys_clk),
    .reset_n                        (reset_n),
    .reg_addr                       (reg_addr),
    .reg_wr_data                    (reg_wr_data),
    .reg_wr_stb                     (reg_wr_stb),
    .reg_rd_stb                     (reg_rd_stb),
    .reg_rd_data                    (reg_rd_data),
    .line_signal_loss_status        (st[0]),
    .system_signal_loss_status      (st[1]),
    .tx_signal_loss_status          (st[2]),
    .tx_clock_missing_status        (st[3]),
    .overcurrent_status             (st[4]),
    .deactivate_code_status         (st[5]),
    .activate_code_status           (st[6]),
    .pattern_sync_status            (st[7]),
    .line_alarm_indication_status   (st[8]),
    .system_alarm_indication_status (st[9]),
    .rx_jitter_fifo_evt             (ev[0]),
    .tx_jitter_fifo_evt             (ev[1]),
    .amplitude_overflow_evt         (ev[2]),
    .irq                            (irq)
  );

  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  function automatic logic [10:0] ad(input int ch, input logic [5:0] off);
    return 11'(ch * 64) + 11'(off);
  endfunction

  function automatic logic [31:0] rnd();
    rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
    return rs;
  endfunction

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr_stb  <= 1'b1;
    reg_addr    <= a;
    reg_wr_data <= d;
    @(posedge sys_clk);
    reg_wr_stb  <= 1'b0;
  endtask

  // The expected byte is queued before the strobe so the monitor never finds it empty
  task automatic rd(input logic [10:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd_stb <= 1'b1;
    reg_addr   <= a;
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd_stb <= 1'b0;
  endtask

  task automatic chk_irq(input logic e);
    @(negedge sys_clk);
    num_checks++;
    if (irq !== e) begin
      n_errors++;
      $display("mismatch at %0t: irq is %b", $time, irq);
    end
  endtask

  task automatic drive_src(input int k, input int ch, input logic v);
    @(posedge sys_clk);
    if (k < 10) st[k][ch] <= v;
    else ev[k-10][ch] <= v;
  endtask

  task automatic src_test(input int k);
    int          ch;
    int          pos;
    logic [10:0] fa;
    logic [10:0] ma;
    logic [10:0] ea;
    logic [7:0]  bitv;
    logic [7:0]  mrst;
    logic [10:0] sa;
    ch   = int'(rnd() % NCH);
    pos  = FLP[k];
    fa   = ad(ch, pos < 8 ? liu_irq_pkg::OFF_FLAGS_A : liu_irq_pkg::OFF_FLAGS_B);
    ma   = ad(ch, pos < 8 ? liu_irq_pkg::OFF_MASK_A : liu_irq_pkg::OFF_MASK_B);
    ea   = ad(ch, liu_irq_pkg::OFF_EDGE_SEL);
    bitv = 8'(1 << (pos % 8));
    mrst = pos < 8 ? liu_irq_pkg::MASK_A_RST : liu_irq_pkg::MASK_B_RST;
    sa   = ad(ch, pos < 8 ? liu_irq_pkg::OFF_STATUS_A : liu_irq_pkg::OFF_STATUS_B);
    drive_src(k, ch, 1'b1);
    if (k >= 10) drive_src(k, ch, 1'b0);
    wait_n(3);
    rd(fa, bitv);
    rd(ad(ch ^ 1, fa[5:0]), 8'h00);
    if (k < 10) rd(sa, bitv);
    chk_irq(1'b0);
    wr(ma, mrst & ~bitv);
    wait_n(3);
    chk_irq(1'b1);
    wr(fa, bitv);
    wait_n(3);
    rd(fa, 8'h00);
    chk_irq(1'b0);
    // A pulse while unmasked must reach irq too, not only a flag set while masked
    if (k >= 10) begin
      drive_src(k, ch, 1'b1);
      drive_src(k, ch, 1'b0);
      wait_n(3);
      chk_irq(1'b1);
      wr(fa, bitv);
      wait_n(3);
      rd(fa, 8'h00);
    end
    wr(ma, mrst);
    if (k < 10) begin
      drive_src(k, ch, 1'b0);
      wait_n(3);
      rd(fa, 8'h00);
      rd(sa, 8'h00);
      drive_src(k, ch, 1'b1);
      drive_src(k, ch, 1'b0);
      wait_n(3);
      rd(fa, bitv);
      wr(fa, bitv);
      wr(ea, 8'(1 << ESB[k]));
      drive_src(k, ch, 1'b1);
      wait_n(3);
      wr(fa, bitv);
      wait_n(3);
      rd(fa, 8'h00);
      drive_src(k, ch, 1'b0);
      wait_n(3);
      rd(fa, bitv);
      wr(fa, bitv);
      wr(ea, 8'h00);
    end
    $display("test source %0d on channel %0d done", k, ch);
  endtask

  always @(posedge sys_clk) rd_seen <= reg_rd_stb;

  // Read data stand only in the cycle after the strobe, so look mid-cycle there
  always @(negedge sys_clk) begin
    logic [7:0] e;
    if (rd_seen === 1'b1) begin
      num_checks++;
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("mismatch at %0t: read without expectation", $time);
      end else begin
        e = exp_q.pop_front();
        if (reg_rd_data !== e) begin
          n_errors++;
          $display("mismatch at %0t: read %h expected %h", $time, reg_rd_data, e);
        end
      end
    end
  end

  initial begin
    #(1_000_000);
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    give_verdict();
  end

  initial begin
    rs          = 32'h37F1;
    reset_n     = 1'b0;
    reg_addr    = 11'h000;
    reg_wr_data = 8'h00;
    reg_wr_stb  = 1'b0;
    reg_rd_stb  = 1'b0;
    n_errors    = 0;
    num_checks  = 0;
    foreach (st[i]) st[i] = '0;
    foreach (ev[i]) ev[i] = '0;
    do_reset();
    for (int c = 0; c < NCH; c++) begin
      es_v[c] = 8'(rnd());
      ma_v[c] = 8'(rnd());
      wr(ad(c, liu_irq_pkg::OFF_EDGE_SEL), es_v[c]);
      wr(ad(c, liu_irq_pkg::OFF_MASK_A), ma_v[c]);
    end
    for (int c = 0; c < NCH; c++) begin
      rd(ad(c, liu_irq_pkg::OFF_EDGE_SEL), es_v[c] & 8'h7F);
      rd(ad(c, liu_irq_pkg::OFF_MASK_A), ma_v[c]);
    end
    wr(ad(0, 6'h1D), 8'h5A);
    rd(ad(0, 6'h1D), 8'h00);
    rd(11'h41B, 8'h00);
    $display("test register copies done");
    // A second reset in mid-run must bring back defaults over the random contents
    do_reset();
    for (int c = 0; c < NCH; c += NCH - 1) begin
      rd(ad(c, liu_irq_pkg::OFF_EDGE_SEL), 8'h00);
      rd(ad(c, liu_irq_pkg::OFF_MASK_A), 8'hFF);
    end
    chk_irq(1'b0);
    $display("test reset values done");
    for (int k = 0; k < 13; k++) begin
      src_test(k);
    end
    // Both loss sources switch together under the one shared select bit
    wr(ad(3, liu_irq_pkg::OFF_EDGE_SEL), 8'(1 << liu_irq_pkg::ES_LOS));
    @(posedge sys_clk);
    st[0][3] <= 1'b1;
    st[1][3] <= 1'b1;
    wait_n(3);
    rd(ad(3, liu_irq_pkg::OFF_FLAGS_A), 8'h03);
    wr(ad(3, liu_irq_pkg::OFF_FLAGS_A), 8'h03);
    @(posedge sys_clk);
    st[0][3] <= 1'b0;
    st[1][3] <= 1'b0;
    wait_n(3);
    rd(ad(3, liu_irq_pkg::OFF_FLAGS_A), 8'h03);
    wr(ad(3, liu_irq_pkg::OFF_FLAGS_A), 8'h03);
    $display("test shared loss select done");
    wait_n(3);
    give_verdict();
  end
endmodule
`default_nettype wire
